// ### src/swcal_cfg.svh
// Purpose: Constants of the standard weight calibration command handler.
// Assumes: Lines are plain ASCII bytes; the first two bytes name the command.
// Notes: Step patterns and default weights are set here; three steps, one external load.
`ifndef SWCAL_CFG_SVH
`define SWCAL_CFG_SVH

`define SWCAL_CH_HDR0 8'h43
`define SWCAL_CH_HDR1 8'h37
`define SWCAL_CH_SP 8'h20
`define SWCAL_CH_CR 8'h0D
`define SWCAL_CH_LF 8'h0A
`define SWCAL_CH_QT 8'h22
`define SWCAL_CH_PLUS 8'h2B
`define SWCAL_CH_MINUS 8'h2D
`define SWCAL_CH_INTOL 8'h30
`define SWCAL_CH_REQ 8'h52
`define SWCAL_CH_WAIT 8'h44
`define SWCAL_CH_PROG 8'h42
`define SWCAL_CH_ACK 8'h41
`define SWCAL_CH_BUSY 8'h49
`define SWCAL_CH_PERR 8'h4C
`define SWCAL_CH_CONF 8'h43
`define SWCAL_CH_UNIT 8'h67
`define SWCAL_CH_DIGIT0 8'h30
`define SWCAL_METHOD_LAST 8'h32
`define SWCAL_STEP_LAST 2'h2
`define SWCAL_LOAD_STEP 2'h1
`define SWCAL_LINE_MAX 5'h10
`define SWCAL_LOAD_POS 5'h05
`define SWCAL_LOAD_MAX 5'h0D
`define SWCAL_PAT_POS 5'h0C
`define SWCAL_VAL0_DEF 64'h0000_0000_3030_2E30
`define SWCAL_VAL1_DEF 64'h0000_3030_2E30_3031
`define SWCAL_VAL2_DEF 64'h0000_3030_2E30_3031
`define SWCAL_VLEN0_DEF 4'h4
`define SWCAL_VLEN12_DEF 4'h6
`define SWCAL_PAT0 8'h30
`define SWCAL_PAT1 8'h31

`endif

// ### src/swcal_pkg.sv
// Purpose: Types shared by the calibration command handler files.
// Assumes: Nothing beyond the constants header.
// Notes: Encodings are internal only.
`default_nettype none
package swcal_pkg;
	typedef enum logic [1:0] {LN_CODE = 2'b00, LN_METHOD = 2'b01, LN_STEP = 2'b10} swcal_line_type;
	typedef enum logic [1:0] {TOL_IN = 2'b00, TOL_ABOVE = 2'b01, TOL_BELOW = 2'b10} swcal_tol_type;
	typedef enum logic [1:0] {PC_QUERY = 2'b00, PC_START = 2'b01, PC_CONFIRM = 2'b10,
		PC_BAD = 2'b11} swcal_pcmd_type;
	typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_LIST = 3'b001, ST_START = 3'b010,
		ST_REQ = 3'b011, ST_WAIT = 3'b100, ST_DONE = 3'b101, ST_ACK = 3'b110} swcal_state_type;
endpackage
`default_nettype wire

// ### src/swcal_line_fmt.sv
// Purpose: Gives the character at a position of one response line.
// Assumes: Fields other than the tolerance, which the caller re-registers every cycle, are held stable while the line is sent.
// Notes: Purely combinational; the caller registers the output byte.
`default_nettype none
`include "swcal_cfg.svh"
module swcal_line_fmt
(
	input wire swcal_pkg::swcal_line_type kind,
	input wire logic [7:0] code,
	input wire logic [7:0] num,
	input wire logic [7:0] stc,
	input wire logic [7:0] tol,
	input wire logic [7:0] pat,
	input wire logic plen,
	input wire logic [63:0] val,
	input wire logic [3:0] vlen,
	input wire logic [4:0] pos,
	output logic [7:0] ch,
	output logic last
);
	import swcal_pkg::*;
	logic [4:0] q;
	logic [4:0] v0;
	logic [4:0] vend;
	logic [4:0] len;
	logic [4:0] vi;

	// Field positions follow from the pattern and value lengths.
	always_comb
	begin
		q = `SWCAL_PAT_POS + {4'h0, plen};
		v0 = q + 5'h03;
		vend = v0 + {1'b0, vlen};
		vi = pos - v0;
		if (kind == LN_CODE)
			len = 5'h04;
		else if (kind == LN_METHOD)
			len = 5'h06;
		else if (vlen != 4'h0)
			len = vend + 5'h03;
		else
			len = vend + 5'h01;
		last = (pos == len + 5'h01);
		ch = `SWCAL_CH_SP;
		if (pos == len)
			ch = `SWCAL_CH_CR;
		else if (last)
			ch = `SWCAL_CH_LF;
		else if (pos == 5'h00)
			ch = `SWCAL_CH_HDR0;
		else if (pos == 5'h01)
			ch = `SWCAL_CH_HDR1;
		else if (pos == 5'h03)
			ch = code;
		else if (pos == 5'h05)
			ch = num;
		else if (pos == 5'h07)
			ch = stc;
		else if (pos == 5'h09)
			ch = tol;
		else if (pos == 5'h0B || pos == q || pos == q + 5'h02)
			ch = `SWCAL_CH_QT;
		else if (plen && pos == `SWCAL_PAT_POS)
			ch = pat;
		else if (pos >= v0 && pos < vend)
			ch = val[{vi[2:0], 3'b000} +: 8];
		else if (vlen == 4'h0 && pos == vend)
			ch = `SWCAL_CH_QT;
		else if (vlen != 4'h0 && pos == vend + 5'h01)
			ch = `SWCAL_CH_UNIT;
		else if (vlen != 4'h0 && pos == vend + 5'h02)
			ch = `SWCAL_CH_QT;
	end
endmodule
`default_nettype wire

// ### src/swcal_cmd.sv
// Purpose: Command handler for the standard weight calibration procedure.
// Assumes: Byte streams, step setting, busy and weighing inputs share sys_clk.
// Notes: One received command is held at a time; a later one while held is lost.
// Behaviour
// - Command with no argument is a query of all supported methods.
// - Query answer: progress line per method, acknowledge line with the last.
// - Command with method starts procedure, confirmation per step-control setting.
// - Unconfirmed run: start line, step progress lines, final acknowledge.
// - Confirmed run: confirm-type request, wait for bare confirm, then capture.
// - After a weight change the request is re-issued and reconfirmed.
// - Acknowledge only when the whole procedure completed.
// - While another command runs, reply busy once and nothing more.
// - Invalid parameter gives parameter error and no start.
// - State field is R when requesting weight, D once the step has been captured.
// - Tolerance field is plus above, minus below, zero within.
// - Placement pattern lists loads to place; empty for built-in weights.
`default_nettype none
`include "swcal_cfg.svh"
module swcal_cmd
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	input wire logic step_confirmation_setting,
	input wire logic other_cmd_busy,
	input wire logic weight_stable,
	input wire swcal_pkg::swcal_tol_type tol_state,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic step_capture,
	output logic cal_active
);
	import swcal_pkg::*;
	logic [7:0] buf_q [0:15];
	logic [4:0] cnt_q;
	logic pend_q;
	swcal_pcmd_type pend_kind_q;
	logic [7:0] pend_m_q;
	logic pend_load_q;
	logic [63:0] pend_val_q;
	logic [3:0] pend_vlen_q;
	logic [63:0] load_vec;
	logic [4:0] llen;
	swcal_state_type state_q;
	logic confirm_q;
	logic [1:0] step_q;
	logic [7:0] meth_q;
	swcal_line_type ln_kind_q;
	logic [7:0] ln_code_q;
	logic [7:0] ln_num_q;
	logic [7:0] ln_st_q;
	logic [7:0] ln_tol_q;
	logic ln_empty_q;
	logic line_go_q;
	logic busy_q;
	logic [4:0] pos_q;
	logic [7:0] fmt_ch;
	logic fmt_last;
	logic tx_idle;
	logic take;
	logic [63:0] val_q [0:2];
	logic [3:0] vlen_q [0:2];
	logic val_we_q;
	logic [1:0] val_sel_q;
	logic [63:0] val_wd_q;
	logic [3:0] vlen_wd_q;
	logic [7:0] pat_cur;
	logic plen_cur;
	logic [7:0] tol_ch;
	logic meth_ok;

	// Loaded weight text sits after the confirm or method field and its space.
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_load
			assign load_vec[8 * g +: 8] = buf_q[5 + g];
		end
	endgenerate
	assign llen = cnt_q - `SWCAL_LOAD_POS;

	// Receive bytes into the line buffer and decode the line at CR.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 5'h00;
			pend_q <= 1'b0;
			pend_kind_q <= PC_BAD;
			pend_m_q <= 8'h00;
			pend_load_q <= 1'b0;
			pend_val_q <= 64'h0;
			pend_vlen_q <= 4'h0;
			for (int i = 0; i < 16; i++)
				buf_q[i] <= 8'h00;
		end
		else
		begin
			if (take)
				pend_q <= 1'b0;
			if (rx_valid && rx_data == `SWCAL_CH_CR)
			begin
				cnt_q <= 5'h00;
				if (cnt_q >= 5'h02 && buf_q[0] == `SWCAL_CH_HDR0 && buf_q[1] == `SWCAL_CH_HDR1
					&& (!pend_q || take))
				begin
					pend_q <= 1'b1;
					pend_m_q <= buf_q[3];
					pend_val_q <= load_vec;
					pend_vlen_q <= llen[3:0];
					pend_load_q <= (cnt_q > 5'h04);
					if (cnt_q == 5'h02)
						pend_kind_q <= PC_QUERY;
					else if (buf_q[2] != `SWCAL_CH_SP || cnt_q == 5'h03 || cnt_q == 5'h05
						|| cnt_q > `SWCAL_LOAD_MAX || (cnt_q > 5'h04 && buf_q[4] != `SWCAL_CH_SP))
						pend_kind_q <= PC_BAD;
					else if (buf_q[3] == `SWCAL_CH_CONF)
						pend_kind_q <= PC_CONFIRM;
					else
						pend_kind_q <= PC_START;
				end
			end
			else if (rx_valid && rx_data != `SWCAL_CH_LF && cnt_q != `SWCAL_LINE_MAX)
			begin
				buf_q[cnt_q[3:0]] <= rx_data;
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// Per-step required weight, reloaded by a start load or a confirm load.
	generate
		for (g = 0; g < 3; g++)
		begin : g_step
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					val_q[g] <= (g == 0) ? `SWCAL_VAL0_DEF : (g == 1) ? `SWCAL_VAL1_DEF
						: `SWCAL_VAL2_DEF;
					vlen_q[g] <= (g == 0) ? `SWCAL_VLEN0_DEF : `SWCAL_VLEN12_DEF;
				end
				else if (val_we_q && val_sel_q == 2'(g))
				begin
					val_q[g] <= val_wd_q;
					vlen_q[g] <= vlen_wd_q;
				end
			end
		end
	endgenerate

	// Step 0 unloads, step 1 takes external load 1, step 2 uses built-in weights.
	always_comb
	begin
		pat_cur = (step_q == 2'h0) ? `SWCAL_PAT0 : `SWCAL_PAT1;
		plen_cur = (step_q != `SWCAL_STEP_LAST);
		unique case (tol_state)
			TOL_ABOVE: tol_ch = `SWCAL_CH_PLUS;
			TOL_BELOW: tol_ch = `SWCAL_CH_MINUS;
			default: tol_ch = `SWCAL_CH_INTOL;
		endcase
	end

	assign tx_idle = !busy_q && !line_go_q;
	assign take = pend_q && tx_idle;
	assign meth_ok = pend_m_q >= `SWCAL_CH_DIGIT0 && pend_m_q <= `SWCAL_METHOD_LAST;

	// Procedure sequencer; a held command is served before the next own line.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			confirm_q <= 1'b0;
			step_q <= 2'h0;
			meth_q <= 8'h00;
			ln_kind_q <= LN_CODE;
			ln_code_q <= 8'h00;
			ln_num_q <= 8'h00;
			ln_st_q <= 8'h00;
			ln_tol_q <= 8'h00;
			ln_empty_q <= 1'b0;
			line_go_q <= 1'b0;
			val_we_q <= 1'b0;
			val_sel_q <= 2'h0;
			val_wd_q <= 64'h0;
			vlen_wd_q <= 4'h0;
			step_capture <= 1'b0;
			cal_active <= 1'b0;
		end
		else
		begin
			line_go_q <= 1'b0;
			val_we_q <= 1'b0;
			step_capture <= 1'b0;
			cal_active <= (state_q != ST_IDLE);
			ln_tol_q <= tol_ch;
			if (take)
			begin
				line_go_q <= 1'b1;
				ln_kind_q <= LN_CODE;
				if (pend_kind_q != PC_CONFIRM && (state_q != ST_IDLE || other_cmd_busy))
					ln_code_q <= `SWCAL_CH_BUSY;
				else if (pend_kind_q == PC_QUERY)
				begin
					line_go_q <= 1'b0;
					meth_q <= `SWCAL_CH_DIGIT0;
					state_q <= ST_LIST;
				end
				else if (pend_kind_q == PC_START && meth_ok)
				begin
					line_go_q <= 1'b0;
					confirm_q <= step_confirmation_setting;
					val_we_q <= pend_load_q;
					val_sel_q <= `SWCAL_LOAD_STEP;
					val_wd_q <= pend_val_q;
					vlen_wd_q <= pend_vlen_q;
					state_q <= ST_START;
				end
				else if (pend_kind_q == PC_CONFIRM && state_q == ST_WAIT && confirm_q)
				begin
					line_go_q <= 1'b0;
					if (pend_load_q)
					begin
						val_we_q <= 1'b1;
						val_sel_q <= step_q;
						val_wd_q <= pend_val_q;
						vlen_wd_q <= pend_vlen_q;
						state_q <= ST_REQ;
					end
					else
					begin
						step_capture <= 1'b1;
						state_q <= ST_DONE;
					end
				end
				else
					ln_code_q <= `SWCAL_CH_PERR;
			end
			else if (tx_idle)
			begin
				unique case (state_q)
					ST_IDLE:
						;
					ST_LIST:
					begin
						line_go_q <= 1'b1;
						ln_kind_q <= LN_METHOD;
						ln_num_q <= meth_q;
						ln_code_q <= (meth_q == `SWCAL_METHOD_LAST) ? `SWCAL_CH_ACK
							: `SWCAL_CH_PROG;
						meth_q <= meth_q + 8'h01;
						if (meth_q == `SWCAL_METHOD_LAST)
							state_q <= ST_IDLE;
					end
					ST_START:
					begin
						line_go_q <= 1'b1;
						ln_kind_q <= LN_CODE;
						ln_code_q <= `SWCAL_CH_PROG;
						step_q <= 2'h0;
						// Clears a wait state left by an earlier run so step 0 is not skipped.
						ln_st_q <= `SWCAL_CH_REQ;
						state_q <= ST_REQ;
					end
					ST_REQ:
					begin
						line_go_q <= 1'b1;
						ln_kind_q <= LN_STEP;
						ln_code_q <= confirm_q ? `SWCAL_CH_CONF : `SWCAL_CH_PROG;
						ln_st_q <= `SWCAL_CH_REQ;
						// The step only advances after a captured one, so a re-issue keeps it.
						if (ln_st_q == `SWCAL_CH_WAIT)
						begin
							step_q <= step_q + 2'h1;
							ln_num_q <= `SWCAL_CH_DIGIT0 + {6'h00, step_q + 2'h1};
						end
						else
							ln_num_q <= `SWCAL_CH_DIGIT0 + {6'h00, step_q};
						ln_empty_q <= 1'b0;
						state_q <= ST_WAIT;
					end
					ST_WAIT:
						if (!confirm_q && weight_stable)
						begin
							step_capture <= 1'b1;
							state_q <= ST_DONE;
						end
					ST_DONE:
					begin
						line_go_q <= 1'b1;
						ln_kind_q <= LN_STEP;
						ln_code_q <= `SWCAL_CH_PROG;
						ln_st_q <= `SWCAL_CH_WAIT;
						ln_num_q <= `SWCAL_CH_DIGIT0 + {6'h00, step_q};
						ln_empty_q <= 1'b1;
						if (step_q == `SWCAL_STEP_LAST)
							state_q <= ST_ACK;
						else
							state_q <= ST_REQ;
					end
					ST_ACK:
					begin
						line_go_q <= 1'b1;
						ln_kind_q <= LN_CODE;
						ln_code_q <= `SWCAL_CH_ACK;
						state_q <= ST_IDLE;
					end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	swcal_line_fmt u_fmt
	(
		.kind(ln_kind_q),
		.code(ln_code_q),
		.num(ln_num_q),
		.stc(ln_st_q),
		.tol(ln_tol_q),
		.pat(pat_cur),
		.plen(plen_cur),
		.val(val_q[step_q]),
		.vlen(ln_empty_q ? 4'h0 : vlen_q[step_q]),
		.pos(pos_q),
		.ch(fmt_ch),
		.last(fmt_last)
	);

	// Byte sender; the last byte leaves busy early so the next line can be set up.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			pos_q <= 5'h00;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end
		else
		begin
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			if (line_go_q)
			begin
				busy_q <= 1'b1;
				pos_q <= 5'h00;
			end
			else if (busy_q && (!tx_valid || tx_ready))
			begin
				tx_valid <= 1'b1;
				tx_data <= fmt_ch;
				pos_q <= pos_q + 5'h01;
				if (fmt_last)
					busy_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/swcal_cmd_properties.sv
// Purpose: Port assertions of the calibration command handler.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Bound to the top module from the bench top file.
`default_nettype none
module swcal_cmd_properties
	import swcal_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	input wire logic step_confirmation_setting,
	input wire logic other_cmd_busy,
	input wire logic weight_stable,
	input wire swcal_pkg::swcal_tol_type tol_state,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic step_capture,
	input wire logic cal_active
);
	timeunit 1ns;
	timeprecision 1ns;
	logic start_q;
	// Marks that the next byte offered opens a line, so the header can be checked.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			start_q <= 1'h1;
		else if (tx_valid && tx_ready)
			start_q <= (tx_data == 8'h0A);
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_take; tx_valid && tx_ready; endsequence
	sequence s_cr; s_take ##0 tx_data == 8'h0D; endsequence
	sequence s_head; start_q ##0 s_take; endsequence
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("tx byte moved before taken");
	property p_lf; s_cr |=> tx_valid && tx_data == 8'h0A; endproperty
	a_lf: assert property (p_lf) else $error("no line feed after return");
	property p_head; s_head |-> tx_data == 8'h43 ##1 tx_valid && tx_data == 8'h37; endproperty
	a_head: assert property (p_head) else $error("line header wrong");
	property p_text;
		tx_valid |-> (tx_data >= 8'h20 && tx_data < 8'h7F) || tx_data == 8'h0D || tx_data == 8'h0A;
	endproperty
	a_text: assert property (p_text) else $error("byte not printable");
	property p_pulse; step_capture |=> !step_capture; endproperty
	a_pulse: assert property (p_pulse) else $error("capture not a pulse");
	property p_act; step_capture |-> cal_active; endproperty
	a_act: assert property (p_act) else $error("capture while idle");
	property p_busy; (!cal_active && other_cmd_busy)[*4] |=> !cal_active; endproperty
	a_busy: assert property (p_busy) else $error("started while busy");
	property p_stable;
		step_capture && !step_confirmation_setting |-> $past(weight_stable) || $past(weight_stable, 2);
	endproperty
	a_stable: assert property (p_stable) else $error("capture without stability");
endmodule
`default_nettype wire

// ### test/swcal_host_model.sv
// Purpose: Host model that sends command lines and sinks response bytes.
// Assumes: Handler inputs change at the falling edge.
// Notes: The sink stalls at random so the output hold is exercised.
`default_nettype none
module swcal_host_model
(
	input wire logic sys_clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	string lines[$];
	string cur = "";
	// Idle values at time zero.
	initial
	begin
		rx_valid = 1'h0;
		rx_data = 8'h00;
		tx_ready = 1'h0;
	end
	// Sends one line byte by byte; idle data is inverted so it is never stale.
	task automatic send(string s);
		string t;
		t = {s, "\r\n"};
		for (int i = 0; i < t.len(); i++)
		begin
			@(negedge sys_clk);
			rx_valid = 1'h1;
			rx_data = t[i];
		end
		@(negedge sys_clk);
		rx_valid = 1'h0;
		rx_data = ~rx_data;
	endtask
	// Random stall of the response sink.
	always @(negedge sys_clk)
		tx_ready <= $urandom_range(0, 3) != 0;
	// Gathers taken bytes; a line closes at its line feed.
	always @(posedge sys_clk)
		if (tx_valid === 1'h1 && tx_ready)
		begin
			if (tx_data == 8'h0A)
			begin
				lines.push_back(cur);
				cur = "";
			end
			else
				cur = {cur, $sformatf("%c", tx_data)};
		end
endmodule
`default_nettype wire

// ### test/swcal_cmd_tb_top.sv
// Purpose: Self-checking bench of the calibration command handler.
// Assumes: The host model drives bytes and sinks the answers.
// Notes: Method, tolerance, stalls and stability come from a fixed seed.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module swcal_cmd_tb_top
	import swcal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic conf_on = 1'h0;
	logic busy = 1'h0;
	logic stable = 1'h0;
	swcal_tol_type tol = TOL_IN;
	wire logic rx_valid;
	wire logic [7:0] rx_data;
	wire logic tx_ready;
	wire logic tx_valid;
	wire logic [7:0] tx_data;
	wire logic step_capture;
	wire logic cal_active;
	int error_cnt = 0;
	int checked = 0;
	int cap_cnt = 0;
	swcal_host_model h (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
	swcal_cmd uut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .step_confirmation_setting(conf_on), .other_cmd_busy(busy),
		.weight_stable(stable), .tol_state(tol), .tx_valid(tx_valid), .tx_data(tx_data),
		.step_capture(step_capture), .cal_active(cal_active));
	// Free-running clock of 100 ns.
	initial
		forever #50 sys_clk = ~sys_clk;
	// Stability flickers so unconfirmed steps wait a random time.
	always @(negedge sys_clk)
		stable <= $urandom_range(0, 1);
	// Counts capture pulses of each run.
	always @(posedge sys_clk)
		if (step_capture === 1'h1)
			cap_cnt++;
	// Packs a line into bits so it prints in hexadecimal.
	function automatic logic [255:0] s2b(string s);
		logic [255:0] r;
		r = 256'h0;
		for (int i = 0; i < s.len(); i++)
			r = {r[247:0], s[i]};
		return r;
	endfunction
	// Expected step line; only step 2 uses built-in weights, so its pattern is empty.
	function automatic string stl(byte c, int k, byte s, string v);
		string p;
		byte t;
		p = k == 0 ? "0" : k == 1 ? "1" : "";
		t = tol == TOL_ABOVE ? 8'h2B : tol == TOL_BELOW ? 8'h2D : 8'h30;
		return $sformatf("C7 %c %0d %c %c \"%s\" \"%s\"", c, k, s, t, p, v);
	endfunction
	task automatic close_out();
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Waits, bounded, for the next line and compares it with its CR.
	task automatic exp(string e);
		string g;
		int n;
		n = 0;
		while (h.lines.size() == 0 && n < 3000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 3000)
		begin
			error_cnt++;
			close_out();
		end
		else
		begin
			g = h.lines.pop_front();
			`CHK(s2b(g), s2b({e, "\r"}))
		end
	endtask
	// Walks the three steps; with confirmation on, each waits for a confirm.
	task automatic steps(bit on, string v1, bit chg);
		byte c;
		string v;
		c = on ? 8'h43 : 8'h42;
		for (int k = 0; k < 3; k++)
		begin
			v = k == 0 ? "0.00 g" : k == 1 ? {v1, " g"} : "100.00 g";
			exp(stl(c, k, 8'h52, v));
			if (on && chg && k == 1)
			begin
				h.send("C7 0");
				exp("C7 I");
				h.send("C7 C 120.00");
				exp(stl(c, k, 8'h52, "120.00 g"));
			end
			if (on)
				h.send("C7 C");
			exp(stl(8'h42, k, 8'h44, ""));
		end
		exp("C7 A");
	endtask
	initial
	begin
		void'($urandom(89044));
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'h1;
		h.send("C7");
		exp("C7 B 0");
		exp("C7 B 1");
		exp("C7 A 2");
		h.send("C7 5");
		exp("C7 L");
		h.send("C7 C");
		exp("C7 L");
		h.send("C7 12");
		exp("C7 L");
		`CHK(cal_active, 1'h0)
		for (int i = 0; i < 4; i++)
		begin
			@(negedge sys_clk);
			tol = swcal_tol_type'(i % 3);
			cap_cnt = 0;
			h.send(i == 3 ? "C7 1 250.5" : $sformatf("C7 %0d", $urandom_range(0, 2)));
			exp("C7 B");
			steps(1'h0, i == 3 ? "250.5" : "100.00", 1'h0);
			`CHK(cap_cnt, 3)
		end
		@(negedge sys_clk);
		busy = 1'h1;
		h.send("C7 2");
		exp("C7 I");
		repeat (200) @(posedge sys_clk);
		`CHK(h.lines.size(), 0)
		@(negedge sys_clk);
		busy = 1'h0;
		conf_on = 1'h1;
		tol = swcal_tol_type'($urandom_range(0, 2));
		cap_cnt = 0;
		h.send("C7 2 300");
		exp("C7 B");
		steps(1'h1, "300", 1'h1);
		`CHK(cap_cnt, 3)
		close_out();
	end
endmodule
bind swcal_cmd swcal_cmd_properties chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
	.step_confirmation_setting(step_confirmation_setting), .other_cmd_busy(other_cmd_busy),
	.weight_stable(weight_stable), .tol_state(tol_state), .tx_valid(tx_valid),
	.tx_data(tx_data), .step_capture(step_capture), .cal_active(cal_active));
`default_nettype wire
